// ===== rtl/synth_cfg_pkg.sv
// Register map, field layout and reset values of the synthesizer config bank
package synth_cfg_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int NREG   = 9;

    // Writing this offset moves all pending values into the active set
    localparam logic [ADDR_W-1:0] OFS_COMMIT        = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_FRAC_DEN_LO   = 6'h0A;
    localparam logic [ADDR_W-1:0] OFS_FRAC_DEN_HI   = 6'h0B;
    localparam logic [ADDR_W-1:0] OFS_FRAC_NUM_LO   = 6'h0E;
    localparam logic [ADDR_W-1:0] OFS_FRAC_NUM_HI   = 6'h0F;
    localparam logic [ADDR_W-1:0] OFS_BUF_POST      = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_DBL_PRE       = 6'h11;
    localparam logic [ADDR_W-1:0] OFS_SR_DIV_CTRL   = 6'h12;
    localparam logic [ADDR_W-1:0] OFS_SR_DELAY_MODE = 6'h13;
    localparam logic [ADDR_W-1:0] OFS_SR_CNT_DELAY  = 6'h14;

    localparam int IDX_DEN_LO  = 0;
    localparam int IDX_DEN_HI  = 1;
    localparam int IDX_NUM_LO  = 2;
    localparam int IDX_NUM_HI  = 3;
    localparam int IDX_BUF     = 4;
    localparam int IDX_PRE     = 5;
    localparam int IDX_SR_DIV  = 6;
    localparam int IDX_SR_MODE = 7;
    localparam int IDX_SR_CNT  = 8;

    localparam logic [DATA_W-1:0] RST_FRAC_DEN_LO   = 16'hDA80;
    localparam logic [DATA_W-1:0] RST_FRAC_DEN_HI   = 16'hFD51;
    localparam logic [DATA_W-1:0] RST_FRAC_NUM_LO   = 16'h0000;
    localparam logic [DATA_W-1:0] RST_FRAC_NUM_HI   = 16'h0000;
    localparam logic [DATA_W-1:0] RST_BUF_POST      = 16'h0001;
    localparam logic [DATA_W-1:0] RST_DBL_PRE       = 16'h1001;
    localparam logic [DATA_W-1:0] RST_SR_DIV_CTRL   = 16'h0030;
    localparam logic [DATA_W-1:0] RST_SR_DELAY_MODE = 16'h01F8;
    localparam logic [DATA_W-1:0] RST_SR_CNT_DELAY  = 16'h0000;

    // Read-only bits are kept out of storage, so they read as zero
    localparam logic [DATA_W-1:0] WMASK_BUF_POST    = 16'h01FF;
    localparam logic [DATA_W-1:0] WMASK_SR_MODE     = 16'h7FFF;
    localparam logic [DATA_W-1:0] WMASK_FULL        = 16'hFFFF;

    localparam logic [ADDR_W-1:0] REG_OFS [NREG] = '{
        OFS_FRAC_DEN_LO, OFS_FRAC_DEN_HI, OFS_FRAC_NUM_LO, OFS_FRAC_NUM_HI,
        OFS_BUF_POST, OFS_DBL_PRE, OFS_SR_DIV_CTRL, OFS_SR_DELAY_MODE,
        OFS_SR_CNT_DELAY};
    localparam logic [DATA_W-1:0] REG_RST [NREG] = '{
        RST_FRAC_DEN_LO, RST_FRAC_DEN_HI, RST_FRAC_NUM_LO, RST_FRAC_NUM_HI,
        RST_BUF_POST, RST_DBL_PRE, RST_SR_DIV_CTRL, RST_SR_DELAY_MODE,
        RST_SR_CNT_DELAY};
    localparam logic [DATA_W-1:0] REG_WMASK [NREG] = '{
        WMASK_FULL, WMASK_FULL, WMASK_FULL, WMASK_FULL, WMASK_BUF_POST,
        WMASK_FULL, WMASK_FULL, WMASK_SR_MODE, WMASK_FULL};

    localparam int BUF_BIT       = 8;
    localparam int POST_MSB      = 7;
    localparam int POST_LSB      = 0;
    localparam int DBL_BIT       = 12;
    localparam int PRE_MSB       = 7;
    localparam int PRE_LSB       = 0;
    localparam int SR_DIV_MSB    = 15;
    localparam int SR_DIV_LSB    = 5;
    localparam int SR_PRE_MSB    = 4;
    localparam int SR_PRE_LSB    = 2;
    localparam int SR_EN_BIT     = 1;
    localparam int SR_MODE_BIT   = 0;
    localparam int DLY_B_MSB     = 14;
    localparam int DLY_B_LSB     = 9;
    localparam int DLY_A_MSB     = 8;
    localparam int DLY_A_LSB     = 3;
    localparam int NONSYNC_BIT   = 2;
    localparam int PULSE_EN_BIT  = 0;
    localparam int PCNT_MSB      = 15;
    localparam int PCNT_LSB      = 12;
    localparam int DLY_D_MSB     = 11;
    localparam int DLY_D_LSB     = 6;
    localparam int DLY_C_MSB     = 5;
    localparam int DLY_C_LSB     = 0;

    // Input pre-divider selector codes
    localparam logic [2:0] SR_PRE_DIV1 = 3'h0;
    localparam logic [2:0] SR_PRE_DIV2 = 3'h1;

endpackage

// ===== rtl/sysref_gen.sv
// SYSREF generator and repeater driven by the active configuration
`timescale 1ns/1ps
`default_nettype none

module sysref_gen
    import synth_cfg_pkg::*;
#(
    parameter int DIV_W = 11
)(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             sysref_on,
    input  wire logic             repeater_select,
    input  wire logic             repeater_unsynced_select,
    input  wire logic             pulsed_select,
    input  wire logic [3:0]       sysref_pulse_total,
    input  wire logic [DIV_W-1:0] div_code,
    input  wire logic [2:0]       pre_select,
    input  wire logic             ext_sysref,
    output logic                  sysref_q
);

    initial
    begin
        if (DIV_W < 1 || DIV_W > 11)
            $error("sysref_gen: DIV_W must lie in 1..11");
    end

    logic [1:0]       pre_cnt_q;
    logic [DIV_W:0]   half_cnt_q;
    logic             level_q;
    logic             burst_q;
    logic [3:0]       left_q;
    logic             rep_q;

    wire tick = (pre_select == SR_PRE_DIV1) ? 1'b1 :
                (pre_select == SR_PRE_DIV2) ? pre_cnt_q[0] :
                (pre_cnt_q == 2'h3);
    // each half period lasts code+2 ticks, whole period 2*code+4
    wire half_end = tick && (half_cnt_q == {1'b0, div_code} + 1'b1);
    wire rise     = half_end && !level_q;
    wire fire     = rise && (!pulsed_select || left_q != 4'h0);
    // synced repeating samples on the divided tick, else passes through
    wire rep_next = repeater_unsynced_select ? ext_sysref
                  : (tick ? ext_sysref : rep_q);
    // internal generation or repeated external signal
    wire src      = repeater_select ? rep_next
                  : (level_q && (!pulsed_select || burst_q));

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pre_cnt_q  <= 2'h0;
            half_cnt_q <= '0;
            level_q    <= 1'b0;
            burst_q    <= 1'b0;
            left_q     <= 4'h0;
            rep_q      <= 1'b0;
            sysref_q   <= 1'b0;
        end
        else if (!sysref_on)
        begin
            pre_cnt_q  <= 2'h0;
            half_cnt_q <= '0;
            level_q    <= 1'b0;
            burst_q    <= 1'b0;
            left_q     <= sysref_pulse_total;
            rep_q      <= 1'b0;
            sysref_q   <= 1'b0;
        end
        else
        begin
            pre_cnt_q  <= pre_cnt_q + 2'h1;
            rep_q      <= rep_next;
            sysref_q   <= src;
            if (half_end)
            begin
                half_cnt_q <= '0;
                level_q    <= !level_q;
            end
            else if (tick)
                half_cnt_q <= half_cnt_q + 1'b1;
            // continuous mode keeps the budget reloaded
            // pulsed mode spends one unit per started pulse
            if (!pulsed_select)
                left_q <= sysref_pulse_total;
            else if (fire)
                left_q <= left_q - 4'h1;
            if (fire)
                burst_q <= 1'b1;
            else if (half_end && level_q)
                burst_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    off_quiet_a: assert property (!sysref_on |=> !sysref_q)
        else $error("sysref active while disabled");
    unsync_pass_a: assert property (sysref_on && repeater_select
        && repeater_unsynced_select |=> sysref_q == $past(ext_sysref))
        else $error("unsynced repeater does not follow input");
    zero_count_a: assert property (sysref_on && pulsed_select
        && !repeater_select && left_q == 4'h0 && !burst_q
        |=> !$rose(burst_q) && (!pulsed_select || !fire))
        else $error("pulse emitted with empty budget");
    burst_gate_a: assert property (sysref_on && pulsed_select
        && !repeater_select && !burst_q && !level_q
        |=> !sysref_q)
        else $error("pulsed output outside a counted pulse");

endmodule // sysref_gen

`default_nettype wire

// ===== rtl/synth_cfg_regs.sv
// Configuration register bank: fraction, reference path and SYSREF control
//
// How it works
// - numerator is two 16-bit halves, reset zero
// - buffering bit defers writes until register 0
// - pre-divisor 1..255, post-divisor 1..255, reset /1
// - doubler enable bit, reset on
// - SYSREF period twice code plus four
// - SYSREF input divided by 1, 2 or 4
// - SYSREF enable gates the whole function
// - source bit picks master or repeater
// - non-sync repeating when bit set in repeater
// - continuous or counted SYSREF pulses
// - pulse count field sets burst length
// - four 6-bit delay fields, first resets 3F
// - denominator is two 16-bit halves
`timescale 1ns/1ps
`default_nettype none

module synth_cfg_regs
    import synth_cfg_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              ext_sysref,
    output logic      [31:0]       frac_numerator,
    output logic      [31:0]       frac_denominator,
    output logic                   write_buffering_on,
    output logic      [7:0]        ref_post_divisor,
    output logic      [7:0]        ref_pre_divisor,
    output logic                   ref_doubler_on,
    output logic      [5:0]        sysref_delay_stage_a,
    output logic      [5:0]        sysref_delay_stage_b,
    output logic      [5:0]        sysref_delay_stage_c,
    output logic      [5:0]        sysref_delay_stage_d,
    output logic                   sysref_out
);

    logic [DATA_W-1:0] shadow_q [NREG];
    logic [DATA_W-1:0] active_q [NREG];
    logic [DATA_W-1:0] rdata_q;
    logic [NREG-1:0]   hit;
    logic [DATA_W-1:0] rd_mux;

    // writing register 0 is the commit strobe
    wire commit    = wr_en && (addr == OFS_COMMIT);
    // Buffering bit acts at once; its own write is never deferred
    wire buffering = shadow_q[IDX_BUF][BUF_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++)
        begin : g_reg
            assign hit[gi] = (addr == REG_OFS[gi]);
            wire wr_hit = wr_en && hit[gi];
            wire [DATA_W-1:0] wval = wdata & REG_WMASK[gi];

            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    shadow_q[gi] <= REG_RST[gi];
                else if (wr_hit)
                    shadow_q[gi] <= wval;
            end

            // commit moves every pending value in one edge
            // direct effect only while buffering is off
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    active_q[gi] <= REG_RST[gi];
                else if (commit)
                    active_q[gi] <= shadow_q[gi];
                else if (wr_hit && !buffering)
                    active_q[gi] <= wval;
            end
        end
    endgenerate

    // Readback shows the last written value, pending or not
    always_comb
    begin
        rd_mux = '0;
        for (int i = 0; i < NREG; i++)
        begin
            if (hit[i])
                rd_mux = rd_mux | shadow_q[i];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata_q <= '0;
        else
            rdata_q <= rd_en ? rd_mux : '0;
    end

    assign rdata = rdata_q;

    assign frac_numerator = {active_q[IDX_NUM_HI], active_q[IDX_NUM_LO]};
    assign frac_denominator = {active_q[IDX_DEN_HI], active_q[IDX_DEN_LO]};
    assign write_buffering_on = buffering;
    // post-divisor is the full 8-bit field
    assign ref_post_divisor = active_q[IDX_BUF][POST_MSB:POST_LSB];
    // only the low byte of the pre-divisor field divides
    assign ref_pre_divisor = active_q[IDX_PRE][PRE_MSB:PRE_LSB];
    assign ref_doubler_on = active_q[IDX_PRE][DBL_BIT];
    assign sysref_delay_stage_a =
        active_q[IDX_SR_MODE][DLY_A_MSB:DLY_A_LSB];
    assign sysref_delay_stage_b =
        active_q[IDX_SR_MODE][DLY_B_MSB:DLY_B_LSB];
    assign sysref_delay_stage_c =
        active_q[IDX_SR_CNT][DLY_C_MSB:DLY_C_LSB];
    assign sysref_delay_stage_d =
        active_q[IDX_SR_CNT][DLY_D_MSB:DLY_D_LSB];

    // SYSREF runs from the active control set
    sysref_gen #(
        .DIV_W (11)
    ) u_sysref (
        .clk                      (clk),
        .rstn                     (rstn),
        .sysref_on                (active_q[IDX_SR_DIV][SR_EN_BIT]),
        .repeater_select          (active_q[IDX_SR_DIV][SR_MODE_BIT]),
        .repeater_unsynced_select (active_q[IDX_SR_MODE][NONSYNC_BIT]),
        .pulsed_select            (active_q[IDX_SR_MODE][PULSE_EN_BIT]),
        .sysref_pulse_total       (active_q[IDX_SR_CNT][PCNT_MSB:PCNT_LSB]),
        .div_code                 (active_q[IDX_SR_DIV][SR_DIV_MSB:SR_DIV_LSB]),
        .pre_select               (active_q[IDX_SR_DIV][SR_PRE_MSB:SR_PRE_LSB]),
        .ext_sysref               (ext_sysref),
        .sysref_q                 (sysref_out)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence num_lo_write;
        wr_en && addr == OFS_FRAC_NUM_LO;
    endsequence

    sequence commit_write;
        wr_en && addr == OFS_COMMIT;
    endsequence

    direct_write_a: assert property (num_lo_write and !buffering
        |=> frac_numerator[15:0] == $past(wdata))
        else $error("direct numerator write not applied");
    deferred_write_a: assert property (num_lo_write and buffering
        |=> $stable(frac_numerator))
        else $error("buffered write took effect early");
    commit_copy_a: assert property (commit_write
        |=> frac_numerator == $past({shadow_q[IDX_NUM_HI],
                                    shadow_q[IDX_NUM_LO]})
            && ref_post_divisor
               == $past(shadow_q[IDX_BUF][POST_MSB:POST_LSB]))
        else $error("commit did not copy pending values");
    pend_then_commit_a: assert property ((num_lo_write and buffering)
        ##[1:8] commit_write
        |=> frac_numerator[15:0] == shadow_q[IDX_NUM_LO])
        else $error("pending value lost before commit");
    ro_bits_zero_a: assert property (rd_en && addr == OFS_BUF_POST
        |=> rdata[15:9] == 7'h00)
        else $error("read-only bits read nonzero");
    read_once_a: assert property (!rd_en |=> rdata == '0)
        else $error("read data outside its cycle");
    mode_write_a: assert property (wr_en && addr == OFS_SR_DELAY_MODE
        && !buffering
        |=> sysref_delay_stage_a == $past(wdata[DLY_A_MSB:DLY_A_LSB])
            && sysref_delay_stage_b == $past(wdata[DLY_B_MSB:DLY_B_LSB]))
        else $error("delay stage fields not applied");
    doubler_write_a: assert property (wr_en && addr == OFS_DBL_PRE
        && !buffering
        |=> ref_doubler_on == $past(wdata[DBL_BIT])
            && ref_pre_divisor == $past(wdata[PRE_MSB:PRE_LSB]))
        else $error("doubler or pre-divisor not applied");

endmodule // synth_cfg_regs

`default_nettype wire

// ===== dv/cfg_host_model.sv
// Host controller model that programs the configuration bank
`timescale 1ns/1ps
`default_nettype none

module cfg_host_model
    import synth_cfg_pkg::*;
(
    input  wire logic              clk,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] wdata,
    output logic                   wr_en,
    output logic                   rd_en,
    input  wire logic [DATA_W-1:0] rdata
);
    initial
    begin
        addr = '0;
        wdata = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    function automatic logic [DATA_W-1:0] guard(
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        case (a)
            6'h10: guard = d & 16'h01FF;
            6'h11: guard = d & 16'h10FF;
            6'h13: guard = d & 16'h7FFD;
            default: guard = d;
        endcase
    endfunction

    // Raw writes only where a scenario means to break the guard
    task automatic wr(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input bit raw);
        @(posedge clk);
        addr <= a;
        wdata <= raw ? d : guard(a, d);
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        // Released lines show the inverse, never a stale match
        addr <= ~a;
        wdata <= ~d;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a,
                      output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule // cfg_host_model

`default_nettype wire

// ===== dv/synth_cfg_regs_bench.sv
// Self-checking bench for the synthesizer configuration bank
`timescale 1ns/1ps
`default_nettype none

module synth_cfg_regs_bench
    import synth_cfg_pkg::*;
();
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic              ext_sysref = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rdata;
    logic [31:0]       num;
    logic [31:0]       den;
    logic              buf_on;
    logic [7:0]        post;
    logic [7:0]        pre;
    logic              dbl;
    logic [5:0]        dly_a;
    logic [5:0]        dly_b;
    logic [5:0]        dly_c;
    logic [5:0]        dly_d;
    logic              sysref_out;
    logic [15:0]       d;
    int                n_mismatch = 0;
    int                tests_run = 0;
    int                n;

    localparam logic [ADDR_W-1:0] T_OFS [9] = '{6'h0A, 6'h0B, 6'h0E,
        6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14};
    localparam logic [15:0] T_RST [9] = '{16'hDA80, 16'hFD51, 16'h0000,
        16'h0000, 16'h0001, 16'h1001, 16'h0030, 16'h01F8, 16'h0000};
    localparam logic [10:0] SR_DIV [4] = '{11'h000, 11'h001, 11'h001,
        11'h7FF};
    localparam logic [2:0] SR_PRE [4] = '{3'h0, 3'h1, 3'h2, 3'h0};
    localparam int PCNT [3] = '{0, 2, 15};

    always #2 clk = ~clk;

    cfg_host_model host (.clk(clk), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));

    synth_cfg_regs dut (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .ext_sysref(ext_sysref), .frac_numerator(num),
        .frac_denominator(den), .write_buffering_on(buf_on),
        .ref_post_divisor(post), .ref_pre_divisor(pre),
        .ref_doubler_on(dbl), .sysref_delay_stage_a(dly_a),
        .sysref_delay_stage_b(dly_b), .sysref_delay_stage_c(dly_c),
        .sysref_delay_stage_d(dly_d), .sysref_out(sysref_out));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Cycles for which the output keeps one level, bounded
    task automatic run_len(input logic lvl, output int c);
        c = 0;
        while (sysref_out === lvl && c < 9000)
        begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask

    task automatic count_rises(input int cyc, output int r);
        logic prev;
        r = 0;
        prev = sysref_out;
        repeat (cyc)
        begin
            @(posedge clk);
            #1;
            if (sysref_out === 1'b1 && prev === 1'b0)
                r++;
            prev = sysref_out;
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        conclude();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check({post, pre, 7'h0, dbl, 2'h0, dly_a}, 32'h0101_013F);
        check(num, 32'h0);
        check(den, 32'hFD51DA80);
        check({buf_on, sysref_out, dly_b, dly_c, dly_d}, 32'h0);
        foreach (T_OFS[i])
        begin
            host.rd(T_OFS[i], d);
            check(d, T_RST[i]);
        end
        host.rd(6'h0C, d);
        check(d, 32'h0);
        $display("Test reset values done");

        host.wr(6'h0E, 16'h1234, 1'b0);
        host.wr(6'h0F, 16'hABCD, 1'b0);
        host.wr(6'h0A, 16'h1111, 1'b0);
        host.wr(6'h0B, 16'h2222, 1'b0);
        host.wr(6'h10, 16'h00FF, 1'b0);
        host.wr(6'h11, 16'h0080, 1'b0);
        host.wr(6'h13, 16'h54A8, 1'b0);
        host.wr(6'h14, 16'h3CCC, 1'b0);
        settle();
        check(num, 32'hABCD1234);
        check(den, 32'h22221111);
        check({buf_on, post, pre, dbl}, 32'h0001FF00);
        check({dly_a, dly_b, dly_c, dly_d}, 32'h0056A333);
        host.wr(6'h10, 16'hFFFF, 1'b1);
        host.rd(6'h10, d);
        check(d, 32'h01FF);
        $display("Test direct writes done");

        host.wr(6'h10, 16'h0101, 1'b0);
        host.wr(6'h0E, 16'h5555, 1'b0);
        host.wr(6'h0F, 16'h6666, 1'b0);
        settle();
        check({buf_on, post, num}, {1'b1, 8'hFF, 32'hABCD1234});
        host.wr(6'h00, 16'h0000, 1'b0);
        settle();
        check({buf_on, post, num}, {1'b1, 8'h01, 32'h66665555});
        host.wr(6'h10, 16'h0001, 1'b0);
        $display("Test buffering done");

        foreach (SR_DIV[i])
        begin
            host.wr(6'h12, 16'h0000, 1'b0);
            settle();
            check(sysref_out, 32'h0);
            host.wr(6'h12, {SR_DIV[i], SR_PRE[i], 2'b10}, 1'b0);
            run_len(1'b0, n);
            run_len(1'b1, n);
            check(n, (SR_DIV[i] + 2) << SR_PRE[i]);
            run_len(1'b0, n);
            check(n, (SR_DIV[i] + 2) << SR_PRE[i]);
        end
        $display("Test master generation done");

        host.wr(6'h13, 16'h01F9, 1'b0);
        foreach (PCNT[i])
        begin
            host.wr(6'h12, 16'h0000, 1'b0);
            host.wr(6'h14, 16'(PCNT[i] << 12), 1'b0);
            host.wr(6'h12, 16'h0002, 1'b0);
            count_rises(150, n);
            check(n, PCNT[i]);
        end
        $display("Test pulsed mode done");

        host.wr(6'h13, 16'h01FC, 1'b0);
        host.wr(6'h12, 16'h0003, 1'b0);
        settle();
        check(sysref_out, 32'h0);
        @(posedge clk);
        ext_sysref <= 1'b1;
        @(posedge clk);
        #1;
        check(sysref_out, 32'h1);
        @(posedge clk);
        #1;
        check(sysref_out, 32'h1);
        // Synced repeater at /4 holds its old level until the first tick
        host.wr(6'h12, 16'h0000, 1'b0);
        host.wr(6'h13, 16'h01F8, 1'b0);
        host.wr(6'h12, 16'h000B, 1'b0);
        repeat (3) @(posedge clk);
        #1;
        check(sysref_out, 32'h0);
        @(posedge clk);
        #1;
        check(sysref_out, 32'h1);
        host.wr(6'h12, 16'h0001, 1'b0);
        settle();
        check(sysref_out, 32'h0);
        $display("Test repeater done");
        conclude();
    end
endmodule // synth_cfg_regs_bench

`default_nettype wire
